// *** logic/table_access_map.svh ***
// Register offsets, field positions, reset values and widths of the table access block
`ifndef TABLE_ACCESS_MAP_SVH
`define TABLE_ACCESS_MAP_SVH

`define TA_REG_PAGE       4'h0
`define TA_REG_KEY        4'h1
`define TA_REG_STATUS     4'h2
`define TA_PAGE_CFG_BIT   7
`define TA_PAGE_RESET     8'h00
`define TA_KEY_RESET      8'h00
`define TA_KEY_W          8
`define TA_PAGE_W         8
`define TA_OFS_W          16
`define TA_WORD_W         24

`endif

// *** logic/table_access_pkg.sv ***
// Types shared by the table access block
package table_access_pkg;

  typedef enum logic [3:0] {
    OP_READ_LOW   = 4'h1,
    OP_READ_HIGH  = 4'h2,
    OP_WRITE_LOW  = 4'h4,
    OP_WRITE_HIGH = 4'h8
  } table_op_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } table_state_e;

endpackage

// *** logic/table_lane_merge.sv ***
// Byte lane merge for table writes into one 16-bit program half
module table_lane_merge (
  // Old and new data
  input  wire logic [15:0] old_word,
  input  wire logic [15:0] new_data,
  // Mode
  input  wire logic        byte_mode,
  input  wire logic        byte_sel,
  // Result
  output logic      [15:0] merged
);

  always_comb
  begin
    if (!byte_mode)
      merged = new_data;
    else if (byte_sel)
      merged = {new_data[7:0], old_word[7:0]};
    else
      merged = {old_word[15:8], new_data[7:0]};
  end

endmodule // table_lane_merge

// *** logic/table_access.sv ***
// Program space table read and write datapath with page and key registers
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "table_access_map.svh"
//
// How it works
// - Low-word table reads and writes reach bits 15 to 0 of a program word directly.
// - Only the high-word table operations touch bits 23 to 16 of a program word.
// - The program address steps by two per 24-bit word, so bit 0 of the offset is dropped.
// - Program memory looks like two 16-bit spaces on one address range, low and high.
// - Every table read and write can be a byte or a 16-bit word transfer.
// - A word low read returns program bits 15 to 0 on data bits 15 to 0.
// - A byte low read returns the upper byte when byte select is 1, else the lower byte.
// - A word high read returns program bits 23 to 16 with data bits 15 to 8 as zero.
// - A byte high read returns the chosen byte, or zero when the phantom byte is chosen.
// - High and low table writes store bytes or words at the addressed location.
// - The page register supplies the upper address bits when ADDR_W is above 15; at the default of 12 the address is offset bits 12 to 1.
// - Page bit 7 at 0 selects user space, at 1 selects configuration space.
// - The key register holds a write-only 8-bit key, zero at reset, reading as zero.
module table_access #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  // Table instruction request from the core
  input  wire logic                    op_valid,
  input  wire table_access_pkg::table_op_e op_code,
  input  wire logic                    op_byte,
  input  wire logic [15:0]             op_offset,
  input  wire logic [15:0]             op_wdata,
  output logic      [15:0]             op_rdata,
  output logic                         op_done,
  // Flash array port, read data in the same cycle as the address
  output logic      [ADDR_W-1:0]       mem_addr,
  output logic                         mem_cfg,
  output logic                         mem_rd,
  output logic                         mem_wr,
  output logic      [`TA_WORD_W-1:0]   mem_wdata,
  output logic      [2:0]              mem_wmask,
  input  wire logic [`TA_WORD_W-1:0]   mem_rdata,
  // Key to the flash controller
  output logic      [`TA_KEY_W-1:0]    unlock_key
);

  // The page and offset together give 22 word address bits at most
  if (ADDR_W < 1 || ADDR_W > 22)
  begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  logic [`TA_PAGE_W-1:0] page_q;
  logic [`TA_KEY_W-1:0]  key_q;
  logic [15:0]           rdata_q;
  logic [15:0]           ordata_q;
  logic                  done_q;
  table_access_pkg::table_state_e state_q;
  table_access_pkg::table_op_e    op_q;
  logic                  byte_q;
  logic                  bsel_q;
  logic [15:0]           wdata_q;
  logic [ADDR_W-1:0]     addr_q;
  logic                  cfg_q;
  logic                  rd_q;
  logic                  wr_q;
  logic [`TA_WORD_W-1:0] mwdata_q;
  logic [2:0]            mwmask_q;
  logic [`TA_WORD_W-1:0] sel_data_d;
  logic [15:0]           low_merged;
  logic [15:0]           high_merged;
  logic [21:0]           full_addr;

  // Page supplies the upper address, offset bit 0 is the byte select
  assign full_addr = {page_q[6:0], op_offset[15:1]};

  always_ff @(posedge clock)
  begin
    if (!nrst)
      page_q <= `TA_PAGE_RESET;
    else if (reg_wr && reg_addr == `TA_REG_PAGE)
      page_q <= reg_wdata[`TA_PAGE_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      key_q <= `TA_KEY_RESET;
    else if (reg_wr && reg_addr == `TA_REG_KEY)
      key_q <= reg_wdata[`TA_KEY_W-1:0];
  end

  assign unlock_key = key_q;

  // Key never reads back so software cannot learn a staged unlock value
  always_ff @(posedge clock)
  begin
    if (!nrst)
      rdata_q <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `TA_REG_PAGE:   rdata_q <= {8'h00, page_q};
        `TA_REG_KEY:    rdata_q <= 16'h0000;
        `TA_REG_STATUS: rdata_q <= {13'h0000, state_q};
        default:        rdata_q <= 16'h0000;
      endcase
    end
    else
      rdata_q <= 16'h0000;
  end

  assign reg_rdata = rdata_q;

  // Accepts one request in idle; requests during a busy cycle are ignored
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state_q  <= table_access_pkg::ST_IDLE;
      op_q     <= table_access_pkg::OP_READ_LOW;
      byte_q   <= 1'b0;
      bsel_q   <= 1'b0;
      wdata_q  <= 16'h0000;
      addr_q   <= '0;
      cfg_q    <= 1'b0;
      rd_q     <= 1'b0;
    end
    else
    begin
      rd_q <= 1'b0;
      unique case (state_q)
        table_access_pkg::ST_IDLE:
        begin
          if (op_valid)
          begin
            op_q    <= op_code;
            byte_q  <= op_byte;
            bsel_q  <= op_offset[0];
            wdata_q <= op_wdata;
            addr_q  <= full_addr[ADDR_W-1:0];
            cfg_q   <= page_q[`TA_PAGE_CFG_BIT];
            rd_q    <= 1'b1;
            state_q <= table_access_pkg::ST_READ;
          end
        end
        table_access_pkg::ST_READ:
        begin
          if (op_q == table_access_pkg::OP_WRITE_LOW || op_q == table_access_pkg::OP_WRITE_HIGH)
            state_q <= table_access_pkg::ST_WRITE;
          else
            state_q <= table_access_pkg::ST_IDLE;
        end
        table_access_pkg::ST_WRITE:
          state_q <= table_access_pkg::ST_IDLE;
        default:
          state_q <= table_access_pkg::ST_IDLE;
      endcase
    end
  end

  // Read steering into the data word
  always_comb
  begin
    sel_data_d = '0;
    if (op_q == table_access_pkg::OP_READ_HIGH)
    begin
      if (!byte_q)
        sel_data_d[15:0] = {8'h00, mem_rdata[23:16]};
      else if (bsel_q)
        sel_data_d[15:0] = 16'h0000;
      else
        sel_data_d[15:0] = {8'h00, mem_rdata[23:16]};
    end
    else
    begin
      if (!byte_q)
        sel_data_d[15:0] = mem_rdata[15:0];
      else if (bsel_q)
        sel_data_d[15:0] = {8'h00, mem_rdata[15:8]};
      else
        sel_data_d[15:0] = {8'h00, mem_rdata[7:0]};
    end
  end

  table_lane_merge u_low_merge (
    .old_word  (mem_rdata[15:0]),
    .new_data  (wdata_q),
    .byte_mode (byte_q),
    .byte_sel  (bsel_q),
    .merged    (low_merged)
  );

  // High half has only one real byte; the phantom byte stays zero
  assign high_merged = (byte_q && bsel_q) ? {8'h00, mem_rdata[23:16]}
                                          : {8'h00, wdata_q[7:0]};

  // Read-modify-write: the word is fetched, merged and written back under a byte mask, low half or high byte
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      wr_q     <= 1'b0;
      mwdata_q <= '0;
      mwmask_q <= 3'h0;
    end
    else if (state_q == table_access_pkg::ST_READ &&
             (op_q == table_access_pkg::OP_WRITE_LOW || op_q == table_access_pkg::OP_WRITE_HIGH))
    begin
      wr_q <= 1'b1;
      if (op_q == table_access_pkg::OP_WRITE_LOW)
      begin
        mwdata_q <= {mem_rdata[23:16], low_merged};
        mwmask_q <= 3'h3;
      end
      else
      begin
        mwdata_q <= {high_merged[7:0], mem_rdata[15:0]};
        mwmask_q <= 3'h4;
      end
    end
    else
    begin
      wr_q     <= 1'b0;
      mwmask_q <= 3'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      ordata_q <= 16'h0000;
      done_q   <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == table_access_pkg::ST_READ &&
                 (op_q == table_access_pkg::OP_READ_LOW || op_q == table_access_pkg::OP_READ_HIGH))
                || state_q == table_access_pkg::ST_WRITE;
      if (state_q == table_access_pkg::ST_READ &&
          (op_q == table_access_pkg::OP_READ_LOW || op_q == table_access_pkg::OP_READ_HIGH))
        ordata_q <= sel_data_d[15:0];
    end
  end

  assign op_rdata  = ordata_q;
  assign op_done   = done_q;
  assign mem_addr  = addr_q;
  assign mem_cfg   = cfg_q;
  assign mem_rd    = rd_q;
  assign mem_wr    = wr_q;
  assign mem_wdata = mwdata_q;
  assign mem_wmask = mwmask_q;

  property p_high_word_top_zero;
    @(posedge clock) disable iff (!nrst)
      (state_q == table_access_pkg::ST_READ && op_q == table_access_pkg::OP_READ_HIGH)
      |=> op_done && op_rdata[15:8] == 8'h00;
  endproperty
  a_high_word_top_zero: assert property (p_high_word_top_zero) else $error("high read top byte");

  property p_phantom_zero;
    @(posedge clock) disable iff (!nrst)
      (state_q == table_access_pkg::ST_READ && op_q == table_access_pkg::OP_READ_HIGH
       && byte_q && bsel_q) |=> op_rdata == 16'h0000;
  endproperty
  a_phantom_zero: assert property (p_phantom_zero) else $error("phantom byte not zero");

  property p_low_word;
    @(posedge clock) disable iff (!nrst)
      (state_q == table_access_pkg::ST_READ && op_q == table_access_pkg::OP_READ_LOW && !byte_q)
      |=> op_rdata == $past(mem_rdata[15:0]);
  endproperty
  a_low_word: assert property (p_low_word) else $error("low word read wrong");

  property p_low_byte;
    @(posedge clock) disable iff (!nrst)
      (state_q == table_access_pkg::ST_READ && op_q == table_access_pkg::OP_READ_LOW && byte_q)
      |=> op_rdata == {8'h00, ($past(bsel_q) ? $past(mem_rdata[15:8]) : $past(mem_rdata[7:0]))};
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte read wrong");

  property p_cfg_select;
    @(posedge clock) disable iff (!nrst)
      (state_q == table_access_pkg::ST_IDLE && op_valid) |=> mem_cfg == $past(page_q[7]) && mem_rd;
  endproperty
  a_cfg_select: assert property (p_cfg_select) else $error("space select wrong");

  property p_addr_step;
    @(posedge clock) disable iff (!nrst)
      (state_q == table_access_pkg::ST_IDLE && op_valid)
      |=> mem_addr == $past(full_addr[ADDR_W-1:0]);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address wrong");

  property p_key_reads_zero;
    @(posedge clock) disable iff (!nrst)
      (reg_rd && reg_addr == `TA_REG_KEY) |=> reg_rdata == 16'h0000;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key readable");

  property p_write_low_keeps_high;
    @(posedge clock) disable iff (!nrst)
      (state_q == table_access_pkg::ST_READ && op_q == table_access_pkg::OP_WRITE_LOW)
      |=> mem_wr && mem_wdata[23:16] == $past(mem_rdata[23:16]) ##1 op_done;
  endproperty
  a_write_low_keeps_high: assert property (p_write_low_keeps_high) else $error("write low");

  property p_byte_write_keep;
    @(posedge clock) disable iff (!nrst)
      (state_q == table_access_pkg::ST_READ && op_q == table_access_pkg::OP_WRITE_LOW
       && byte_q && !bsel_q) |=> mem_wdata[15:8] == $past(mem_rdata[15:8]);
  endproperty
  a_byte_write_keep: assert property (p_byte_write_keep) else $error("byte write clobbers");

endmodule // table_access

// *** dv/flash_array_model.sv ***
// Behavioural program flash array on the far side of the table access block
module flash_array_model #(
  parameter int unsigned ADDR_W = 22
) (
  // Clock
  input  wire logic              clock,
  // Array port
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_cfg,
  input  wire logic              mem_rd,
  input  wire logic              mem_wr,
  input  wire logic [23:0]       mem_wdata,
  input  wire logic [2:0]        mem_wmask,
  output logic      [23:0]       mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [23:0] arr [logic [ADDR_W:0]];
  logic [23:0] word_d;

  // The block samples the word in the cycle that mem_rd stands, so the lookup is combinational;
  // outside a read the inverse shows, which exposes sampling at the wrong cycle
  always_comb
  begin
    word_d = 24'h000000;
    if (arr.exists({mem_cfg, mem_addr}))
      word_d = arr[{mem_cfg, mem_addr}];
    if (!mem_rd)
      word_d = ~word_d;
  end

  assign mem_rdata = word_d;

  always @(posedge clock)
  begin
    if (mem_wr)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (mem_wmask[b])
        begin
          arr[{mem_cfg, mem_addr}][8*b +: 8] = mem_wdata[8*b +: 8];
        end
      end
    end
  end
endmodule // flash_array_model

// *** dv/table_access_test.sv ***
// Self-checking bench for the table access block
`include "table_access_map.svh"
module table_access_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                            clock     = 1'b0;
  logic                            nrst      = 1'b0;
  logic [3:0]                      reg_addr  = 4'h0;
  logic [15:0]                     reg_wdata = 16'h0000;
  logic                            reg_wr    = 1'b0;
  logic                            reg_rd    = 1'b0;
  logic [15:0]                     reg_rdata;
  logic                            op_valid  = 1'b0;
  table_access_pkg::table_op_e     op_code   = table_access_pkg::OP_READ_LOW;
  logic                            op_byte   = 1'b0;
  logic [15:0]                     op_offset = 16'h0000;
  logic [15:0]                     op_wdata  = 16'h0000;
  logic [15:0]                     op_rdata;
  logic                            op_done;
  logic [21:0]                     mem_addr;
  logic                            mem_cfg;
  logic                            mem_rd;
  logic                            mem_wr;
  logic [23:0]                     mem_wdata;
  logic [2:0]                      mem_wmask;
  logic [23:0]                     mem_rdata;
  logic [7:0]                      unlock_key;
  int                              failures  = 0;
  int                              checked   = 0;
  logic [15:0]                     res;

  table_access #(.ADDR_W(22)) u_table_access (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_code(op_code), .op_byte(op_byte), .op_offset(op_offset),
    .op_wdata(op_wdata), .op_rdata(op_rdata), .op_done(op_done), .mem_addr(mem_addr),
    .mem_cfg(mem_cfg), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_wmask(mem_wmask), .mem_rdata(mem_rdata), .unlock_key(unlock_key));

  flash_array_model #(.ADDR_W(22)) u_flash_array_model (.clock(clock), .mem_addr(mem_addr),
    .mem_cfg(mem_cfg), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_wmask(mem_wmask), .mem_rdata(mem_rdata));

  initial
  begin
    forever #5 clock = ~clock;
  end

  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Array index: configuration flag, page low bits, offset without the byte select
  function automatic logic [22:0] ix(logic [7:0] pg, logic [15:0] ofs);
    return {pg[7], pg[6:0], ofs[15:1]};
  endfunction

  task automatic reg_write(logic [3:0] a, logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(logic [3:0] a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    res = reg_rdata;
  endtask

  task automatic op(table_access_pkg::table_op_e c, logic b, logic [15:0] ofs, logic [15:0] d);
    op_valid  <= 1'b1;
    op_code   <= c;
    op_byte   <= b;
    op_offset <= ofs;
    op_wdata  <= d;
    @(posedge clock);
    op_valid  <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      if (op_done === 1'b1)
        break;
      if (i == 7)
        check("op_done", 1'b0, 1'b1);
    end
    res = op_rdata;
  endtask

  task automatic t_regs();
    check("key_reset", unlock_key, 8'h00);
    reg_read(`TA_REG_PAGE);
    check("page_reset", res, 16'h0000);
    reg_read(`TA_REG_STATUS);
    check("status_idle", res, 16'h0001);
    reg_write(`TA_REG_KEY, 16'hff5a);
    reg_read(`TA_REG_KEY);
    check("key_read", res, 16'h0000);
    check("key_out", unlock_key, 8'h5a);
    reg_write(4'hf, 16'h1234);
    reg_read(4'hf);
    check("unmapped", res, 16'h0000);
  endtask

  task automatic t_reads();
    u_flash_array_model.arr[ix(8'h00, 16'h0010)] = 24'habcdef;
    u_flash_array_model.arr[ix(8'h00, 16'h0012)] = 24'h123456;
    op(table_access_pkg::OP_READ_LOW, 1'b0, 16'h0010, 16'h0000);
    check("rd_low_word", res, 16'hcdef);
    op(table_access_pkg::OP_READ_LOW, 1'b0, 16'h0012, 16'h0000);
    check("rd_low_next", res, 16'h3456);
    op(table_access_pkg::OP_READ_LOW, 1'b1, 16'h0010, 16'h0000);
    check("rd_low_b0", res[7:0], 8'hef);
    op(table_access_pkg::OP_READ_LOW, 1'b1, 16'h0011, 16'h0000);
    check("rd_low_b1", res[7:0], 8'hcd);
    op(table_access_pkg::OP_READ_HIGH, 1'b0, 16'h0012, 16'h0000);
    check("rd_high_word", res, 16'h0012);
    op(table_access_pkg::OP_READ_HIGH, 1'b1, 16'h0010, 16'h0000);
    check("rd_high_b0", res[7:0], 8'hab);
    op(table_access_pkg::OP_READ_HIGH, 1'b1, 16'h0011, 16'h0000);
    check("rd_high_phantom", res, 16'h0000);
  endtask

  task automatic t_page();
    u_flash_array_model.arr[ix(8'h85, 16'h0010)] = 24'h776655;
    u_flash_array_model.arr[ix(8'h05, 16'h0010)] = 24'h112233;
    reg_write(`TA_REG_PAGE, 16'h0085);
    reg_read(`TA_REG_PAGE);
    check("page_read", res, 16'h0085);
    op(table_access_pkg::OP_READ_LOW, 1'b0, 16'h0010, 16'h0000);
    check("rd_cfg", res, 16'h6655);
    reg_write(`TA_REG_PAGE, 16'h0005);
    op(table_access_pkg::OP_READ_HIGH, 1'b0, 16'h0010, 16'h0000);
    check("rd_user", res, 16'h0011);
    reg_write(`TA_REG_PAGE, 16'h0000);
  endtask

  task automatic t_writes();
    u_flash_array_model.arr[ix(8'h00, 16'h0040)] = 24'haabbcc;
    op(table_access_pkg::OP_WRITE_LOW, 1'b0, 16'h0040, 16'h1234);
    check("wr_low_word", u_flash_array_model.arr[ix(8'h00, 16'h0040)], 24'haa1234);
    op(table_access_pkg::OP_WRITE_LOW, 1'b1, 16'h0041, 16'h0099);
    check("wr_low_b1", u_flash_array_model.arr[ix(8'h00, 16'h0040)], 24'haa9934);
    op(table_access_pkg::OP_WRITE_HIGH, 1'b0, 16'h0040, 16'h0056);
    check("wr_high_word", u_flash_array_model.arr[ix(8'h00, 16'h0040)], 24'h569934);
    op(table_access_pkg::OP_WRITE_HIGH, 1'b1, 16'h0041, 16'h0077);
    check("wr_high_ph", u_flash_array_model.arr[ix(8'h00, 16'h0040)], 24'h569934);
    op(table_access_pkg::OP_WRITE_HIGH, 1'b1, 16'h0040, 16'h0042);
    check("wr_high_b0", u_flash_array_model.arr[ix(8'h00, 16'h0040)], 24'h429934);
    op(table_access_pkg::OP_WRITE_LOW, 1'b1, 16'h0040, 16'h1177);
    check("wr_low_b0", u_flash_array_model.arr[ix(8'h00, 16'h0040)], 24'h429977);
  endtask

  // Each task is a few dozen cycles, so this limit only trips on a hang
  initial
  begin
    repeat (5000) @(posedge clock);
    failures++;
    test_done();
  end

  initial
  begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_regs();
    t_reads();
    t_page();
    t_writes();
    test_done();
  end
endmodule // table_access_test
